// [scm_pkg.sv]
// Package with shared constants plus the divider chain module
`default_nettype none

package scm_pkg;
  localparam logic [3:0] OFS_SYSCLK_SEL = 4'h0;
  localparam logic [3:0] OFS_FAST_RC = 4'h4;
  localparam logic [3:0] OFS_FAST_XT = 4'h8;
  localparam logic [3:0] OFS_SLOW_XT = 4'hc;
  localparam int SEL_LSB = 5;
  localparam int FHS_BIT = 3;
  localparam int FSS_BIT = 2;
  localparam int FHID_BIT = 1;
  localparam int FSID_BIT = 0;
  localparam int RCF_LSB = 2;
  localparam int FLAG_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int RANGE_BIT = 2;
  localparam logic [2:0] SEL_FAST = 3'h0;
  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic [2:0] RCF_RESET = 3'h0;
  localparam logic RC_EN_RESET = 1'b1;
  localparam int DIV_STAGES = 6;
  localparam int RTC_DIV_W = 3;
  localparam int NPIN = 7;
  localparam int PIN_RC = 0;
  localparam int PIN_XT = 1;
  localparam int PIN_INTERNAL_SLOW_RC = 2;
  localparam int PIN_LXT = 3;
  localparam int PIN_RC_RDY = 4;
  localparam int PIN_XT_RDY = 5;
  localparam int PIN_LXT_RDY = 6;
  typedef enum logic [5:0] {
    SCM_FAST = 6'h01,
    SCM_SLOW = 6'h02,
    SCM_SLEEP = 6'h04,
    SCM_IDLE0 = 6'h08,
    SCM_IDLE1 = 6'h10,
    SCM_IDLE2 = 6'h20
  } scm_mode_e;
endpackage

`timescale 1ns/1ns

// Ripple-free binary divider counted on a sampled clock edge
module scm_div_chain #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  input wire logic run,
  output logic [WIDTH-1:0] count
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (!run) begin
        count <= '0;
      end else if (tick) begin
        count <= count + WIDTH'(1);
      end
    end
  end
endmodule // scm_div_chain

`default_nettype wire

// [scm_clock_mode.sv]
// System clock source selection and power mode control with APB registers
//
// How it works
// R01 - Select code picks fH divided or slow
// R02 - Fast source bit: RC or crystal
// R03 - Slow source bit: slow RC or crystal
// R04 - Fast idle bit keeps fast oscillator running in halt
// R05 - Slow idle bit keeps slow oscillator running in halt
// R06 - Halt with both zero enters sleep
// R07 - Fast zero, slow one enters idle0
// R08 - Both one enters idle1
// R09 - Fast one, slow zero enters idle2
// R10 - Slow mode fast clock follows enable
// R11 - Fast clock kept for peripherals if enabled
// R12 - Slow crystal enable runs it always
// R13 - Sleep feeds slow crystal divided by eight
// R14 - Select register resets zero, bit four zero
// R15 - Enable or retune clears then sets stable
// R16 - RC frequency code table
// R17 - Slow switch waits for slow stable
// R18 - New RC frequency applied once stable
// R19 - Idle system clock runs if source runs; idle2 gates the slow select even when the slow crystal runs
// R20 - Source and ratio changes are glitch-free
`timescale 1ns/1ns
`default_nettype none

module scm_clock_mode #(
  parameter int DIV_W = scm_pkg::DIV_STAGES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic internal_fast_rc,
  input wire logic external_fast_crystal,
  input wire logic internal_slow_rc,
  input wire logic external_slow_crystal,
  input wire logic fast_rc_ready,
  input wire logic fast_crystal_ready,
  input wire logic slow_crystal_ready,
  output logic system_clock,
  output logic fast_periph_clock,
  output logic slow_periph_clock,
  output logic rtc_clock,
  output logic core_run,
  output logic fast_rc_run,
  output logic fast_crystal_run,
  output logic slow_rc_run,
  output logic slow_crystal_run,
  output logic [2:0] fast_rc_freq_applied,
  output logic fast_crystal_range_out,
  output logic [5:0] mode
);
  if (DIV_W < scm_pkg::DIV_STAGES) begin : g_chk
    $error("DIV_W too small for a divide by 64");
  end

  // Registers
  logic [2:0] sysclk_source_sel;
  logic fast_source_sel;
  logic slow_source_sel;
  logic fast_idle_keep;
  logic slow_idle_keep;
  logic [2:0] fast_rc_freq_sel;
  logic fast_rc_enable;
  logic fast_rc_stable;
  logic fast_crystal_range;
  logic fast_crystal_enable;
  logic fast_crystal_stable;
  logic slow_crystal_enable;
  logic slow_crystal_stable;

  scm_pkg::scm_mode_e state;
  scm_pkg::scm_mode_e next_state;
  logic [2:0] cur_sel;
  logic cur_fast_src;
  logic cur_slow_src;

  // Pin synchronisers
  logic [scm_pkg::NPIN-1:0] pin_raw;
  logic [scm_pkg::NPIN-1:0] pin_meta;
  logic [scm_pkg::NPIN-1:0] pin_sync;
  logic [scm_pkg::NPIN-1:0] pin_prev;

  logic wr_en;
  logic rd_en;
  logic halted;
  logic sleeping;
  logic fast_lvl;
  logic fast_rise;
  logic slow_lvl;
  logic fast_stable;
  logic slow_stable;
  logic [DIV_W-1:0] div_count;
  logic [scm_pkg::RTC_DIV_W-1:0] rtc_count;
  logic sel_lvl_cur;
  logic sel_lvl_new;
  logic sysclk_allow;
  logic [2:0] want_sel;
  logic want_ready;

  function automatic logic addr_is(input logic [31:0] a, input logic [3:0] ofs);
    addr_is = (a[31:4] == 28'h0000000) && (a[3:0] == ofs);
  endfunction

  function automatic logic sel_level(input logic [2:0] sel, input logic f_lvl,
                                     input logic s_lvl, input logic [DIV_W-1:0] cnt);
    if (sel == scm_pkg::SEL_SLOW) begin
      sel_level = s_lvl;
    end else if (sel == scm_pkg::SEL_FAST) begin
      sel_level = f_lvl;
    end else begin
      sel_level = cnt[sel - 3'h1];
    end
  endfunction

  assign pin_raw = {slow_crystal_ready, fast_crystal_ready, fast_rc_ready,
                    external_slow_crystal, internal_slow_rc,
                    external_fast_crystal, internal_fast_rc};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else if (ce) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // APB slave: zero wait, error on unmapped address
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    if (addr_is(paddr, scm_pkg::OFS_SYSCLK_SEL) || addr_is(paddr, scm_pkg::OFS_FAST_RC) ||
        addr_is(paddr, scm_pkg::OFS_FAST_XT) || addr_is(paddr, scm_pkg::OFS_SLOW_XT)) begin
      pslverr = 1'b0;
    end else begin
      pslverr = psel && penable;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (ce && rd_en && !penable) begin
      if (addr_is(paddr, scm_pkg::OFS_SYSCLK_SEL)) begin
        prdata <= {24'h000000, sysclk_source_sel, 1'b0, fast_source_sel, // R14
                   slow_source_sel, fast_idle_keep, slow_idle_keep};
      end else if (addr_is(paddr, scm_pkg::OFS_FAST_RC)) begin
        prdata <= {27'h0000000, fast_rc_freq_sel, fast_rc_stable, fast_rc_enable};
      end else if (addr_is(paddr, scm_pkg::OFS_FAST_XT)) begin
        prdata <= {29'h00000000, fast_crystal_range, fast_crystal_stable,
                   fast_crystal_enable};
      end else if (addr_is(paddr, scm_pkg::OFS_SLOW_XT)) begin
        prdata <= {30'h00000000, slow_crystal_stable, slow_crystal_enable};
      end else begin
        prdata <= '0;
      end
    end
  end

  // Select register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sysclk_source_sel <= scm_pkg::SEL_FAST; // R14
      fast_source_sel <= 1'b0;
      slow_source_sel <= 1'b0;
      fast_idle_keep <= 1'b0;
      slow_idle_keep <= 1'b0;
    end else if (ce && wr_en && addr_is(paddr, scm_pkg::OFS_SYSCLK_SEL)) begin
      sysclk_source_sel <= pwdata[scm_pkg::SEL_LSB +: 3];
      fast_source_sel <= pwdata[scm_pkg::FHS_BIT];
      slow_source_sel <= pwdata[scm_pkg::FSS_BIT];
      fast_idle_keep <= pwdata[scm_pkg::FHID_BIT];
      slow_idle_keep <= pwdata[scm_pkg::FSID_BIT];
    end
  end

  // Fast RC control and stable flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_rc_freq_sel <= scm_pkg::RCF_RESET;
      fast_rc_enable <= scm_pkg::RC_EN_RESET;
      fast_rc_stable <= 1'b0;
    end else if (ce) begin
      if (wr_en && addr_is(paddr, scm_pkg::OFS_FAST_RC)) begin
        fast_rc_freq_sel <= pwdata[scm_pkg::RCF_LSB +: 3];
        fast_rc_enable <= pwdata[scm_pkg::EN_BIT];
        if ((pwdata[scm_pkg::EN_BIT] && !fast_rc_enable) ||
            (pwdata[scm_pkg::RCF_LSB +: 3] != fast_rc_freq_sel)) begin
          fast_rc_stable <= 1'b0; // R15
        end
      end else if (!fast_rc_run) begin
        fast_rc_stable <= 1'b0;
      end else if (pin_sync[scm_pkg::PIN_RC_RDY]) begin
        fast_rc_stable <= 1'b1; // R15
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_rc_freq_applied <= scm_pkg::RCF_RESET;
    end else if (ce && fast_rc_stable) begin
      fast_rc_freq_applied <= fast_rc_freq_sel; // R16 R18
    end
  end

  // Fast crystal control; range locked while enabled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_crystal_range <= 1'b0;
      fast_crystal_enable <= 1'b0;
      fast_crystal_stable <= 1'b0;
    end else if (ce) begin
      if (wr_en && addr_is(paddr, scm_pkg::OFS_FAST_XT)) begin
        fast_crystal_enable <= pwdata[scm_pkg::EN_BIT];
        if (!fast_crystal_enable) begin
          fast_crystal_range <= pwdata[scm_pkg::RANGE_BIT];
        end
        if (pwdata[scm_pkg::EN_BIT] && !fast_crystal_enable) begin
          fast_crystal_stable <= 1'b0; // R15
        end
      end else if (!fast_crystal_run) begin
        fast_crystal_stable <= 1'b0;
      end else if (pin_sync[scm_pkg::PIN_XT_RDY]) begin
        fast_crystal_stable <= 1'b1; // R15
      end
    end
  end

  // Slow crystal control
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slow_crystal_enable <= 1'b0;
      slow_crystal_stable <= 1'b0;
    end else if (ce) begin
      if (wr_en && addr_is(paddr, scm_pkg::OFS_SLOW_XT)) begin
        slow_crystal_enable <= pwdata[scm_pkg::EN_BIT];
        if (pwdata[scm_pkg::EN_BIT] && !slow_crystal_enable) begin
          slow_crystal_stable <= 1'b0; // R15
        end
      end else if (!slow_crystal_enable) begin
        slow_crystal_stable <= 1'b0;
      end else if (pin_sync[scm_pkg::PIN_LXT_RDY]) begin
        slow_crystal_stable <= 1'b1; // R15
      end
    end
  end

  // Power mode machine
  always_comb begin
    next_state = state;
    case (state)
      scm_pkg::SCM_FAST, scm_pkg::SCM_SLOW: begin
        if (halt_req) begin
          if (!fast_idle_keep && !slow_idle_keep) begin
            next_state = scm_pkg::SCM_SLEEP; // R06
          end else if (!fast_idle_keep) begin
            next_state = scm_pkg::SCM_IDLE0; // R07
          end else if (slow_idle_keep) begin
            next_state = scm_pkg::SCM_IDLE1; // R08
          end else begin
            next_state = scm_pkg::SCM_IDLE2; // R09
          end
        end else if (cur_sel == scm_pkg::SEL_SLOW) begin
          next_state = scm_pkg::SCM_SLOW;
        end else begin
          next_state = scm_pkg::SCM_FAST;
        end
      end
      scm_pkg::SCM_SLEEP, scm_pkg::SCM_IDLE0, scm_pkg::SCM_IDLE1,
      scm_pkg::SCM_IDLE2: begin
        if (wake_req) begin
          next_state = (cur_sel == scm_pkg::SEL_SLOW) ? scm_pkg::SCM_SLOW :
                                                       scm_pkg::SCM_FAST;
        end
      end
      default: begin
        next_state = scm_pkg::SCM_FAST;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= scm_pkg::SCM_FAST;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign halted = !(state == scm_pkg::SCM_FAST || state == scm_pkg::SCM_SLOW);
  assign sleeping = (state == scm_pkg::SCM_SLEEP);

  // Oscillator run controls
  always_comb begin
    fast_rc_run = fast_rc_enable && (!halted || fast_idle_keep); // R04 R10 R11
    fast_crystal_run = fast_crystal_enable && (!halted || fast_idle_keep); // R04 R10 R11
    slow_rc_run = !halted || slow_idle_keep; // R05
    slow_crystal_run = slow_crystal_enable; // R12
  end

  // Source levels from the applied selections
  assign fast_lvl = cur_fast_src ? pin_sync[scm_pkg::PIN_XT] : pin_sync[scm_pkg::PIN_RC];
  assign fast_rise = cur_fast_src ? (pin_sync[scm_pkg::PIN_XT] && !pin_prev[scm_pkg::PIN_XT]) :
                                    (pin_sync[scm_pkg::PIN_RC] && !pin_prev[scm_pkg::PIN_RC]);
  assign slow_lvl = cur_slow_src ? pin_sync[scm_pkg::PIN_LXT] : pin_sync[scm_pkg::PIN_INTERNAL_SLOW_RC];
  assign fast_stable = cur_fast_src ? fast_crystal_stable : fast_rc_stable;
  assign slow_stable = slow_source_sel ? slow_crystal_stable : 1'b1;

  scm_div_chain #(
    .WIDTH(DIV_W)
  ) u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .tick(fast_rise),
    .run(fast_rc_run || fast_crystal_run),
    .count(div_count)
  );

  // Switch selection only when old and new clocks are both low
  assign want_sel = sysclk_source_sel;
  assign want_ready = (want_sel == scm_pkg::SEL_SLOW) ? slow_stable : fast_stable; // R17
  assign sel_lvl_cur = sel_level(cur_sel, fast_lvl, slow_lvl, div_count);
  assign sel_lvl_new = sel_level(want_sel, fast_lvl, slow_lvl, div_count);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_sel <= scm_pkg::SEL_FAST;
      cur_fast_src <= 1'b0;
      cur_slow_src <= 1'b0;
    end else if (ce) begin
      if (want_sel != cur_sel && want_ready && !sel_lvl_cur && !sel_lvl_new &&
          !system_clock) begin
        cur_sel <= want_sel; // R01 R17 R20
      end
      if (fast_source_sel != cur_fast_src && !pin_sync[scm_pkg::PIN_RC] &&
          !pin_sync[scm_pkg::PIN_XT] && !system_clock) begin
        cur_fast_src <= fast_source_sel; // R02 R20
      end
      if (slow_source_sel != cur_slow_src && !pin_sync[scm_pkg::PIN_INTERNAL_SLOW_RC] &&
          !pin_sync[scm_pkg::PIN_LXT] && !system_clock) begin
        cur_slow_src <= slow_source_sel; // R03 R20
      end
    end
  end

  // System clock gating per mode
  always_comb begin
    case (state)
      scm_pkg::SCM_SLEEP: sysclk_allow = 1'b0; // R06
      scm_pkg::SCM_IDLE0: sysclk_allow = (cur_sel == scm_pkg::SEL_SLOW); // R07 R19
      scm_pkg::SCM_IDLE2: sysclk_allow = (cur_sel != scm_pkg::SEL_SLOW); // R09 R19
      default: sysclk_allow = 1'b1; // R08
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      system_clock <= 1'b0;
    end else if (ce) begin
      system_clock <= sysclk_allow && sel_lvl_cur; // R01 R19
    end
  end

  // Slow crystal divide by eight for sleep
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rtc_count <= '0;
    end else if (ce) begin
      if (!slow_crystal_enable) begin
        rtc_count <= '0;
      end else if (pin_sync[scm_pkg::PIN_LXT] && !pin_prev[scm_pkg::PIN_LXT]) begin
        rtc_count <= rtc_count + scm_pkg::RTC_DIV_W'(1); // R13
      end
    end
  end

  // Peripheral and calendar clocks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_periph_clock <= 1'b0;
      slow_periph_clock <= 1'b0;
      rtc_clock <= 1'b0;
      core_run <= 1'b0;
      fast_crystal_range_out <= 1'b0;
    end else if (ce) begin
      fast_periph_clock <= (cur_fast_src ? fast_crystal_run : fast_rc_run) && fast_lvl; // R11
      slow_periph_clock <= slow_lvl && (!halted || slow_idle_keep); // R05 R07 R08
      if (!slow_crystal_enable) begin
        rtc_clock <= 1'b0;
      end else if (sleeping) begin
        rtc_clock <= rtc_count[scm_pkg::RTC_DIV_W-1]; // R13
      end else begin
        rtc_clock <= pin_sync[scm_pkg::PIN_LXT]; // R12
      end
      core_run <= !halted;
      fast_crystal_range_out <= fast_crystal_range;
    end
  end

  assign mode = state;
endmodule // scm_clock_mode

`default_nettype wire

// [scm_clock_mode_props.sv]
// Checker for halt modes, oscillator gating and select register
`timescale 1ns/1ns
`default_nettype none
module scm_clock_mode_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic halt_req,
  input wire logic [5:0] mode,
  input wire logic core_run,
  input wire logic fast_rc_run,
  input wire logic fast_crystal_run,
  input wire logic slow_rc_run,
  input wire logic slow_crystal_run,
  input wire logic slow_periph_clock
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0] idle_sh;
  logic xt_sh;
  logic wr;
  logic hv;
  assign wr = psel && penable && pwrite && ce;
  assign hv = (mode == 6'h01 || mode == 6'h02) && halt_req && ce;
  // Shadow of idle bits and slow crystal enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_sh <= 2'h0;
      xt_sh <= 1'b0;
    end else if (wr && paddr == 32'h0) begin
      idle_sh <= pwdata[1:0];
    end else if (wr && paddr == 32'hc) begin
      xt_sh <= pwdata[0];
    end
  end
  property p_sleep; hv && idle_sh == 2'h0 |=> mode == 6'h04; endproperty
  a_sleep: assert property (p_sleep) else $error("halt missed sleep");
  property p_idle0; hv && idle_sh == 2'h1 |=> mode == 6'h08; endproperty
  a_idle0: assert property (p_idle0) else $error("halt missed idle0");
  property p_idle1; hv && idle_sh == 2'h3 |=> mode == 6'h10; endproperty
  a_idle1: assert property (p_idle1) else $error("halt missed idle1");
  property p_idle2; hv && idle_sh == 2'h2 |=> mode == 6'h20; endproperty
  a_idle2: assert property (p_idle2) else $error("halt missed idle2");
  property p_fast_off; mode == 6'h04 || mode == 6'h08 |-> !fast_rc_run && !fast_crystal_run;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("fast osc runs");
  property p_slow_off; mode == 6'h04 || mode == 6'h20 |-> !slow_rc_run; endproperty
  a_slow_off: assert property (p_slow_off) else $error("slow osc runs");
  property p_xt_on; xt_sh |-> slow_crystal_run; endproperty
  a_xt_on: assert property (p_xt_on) else $error("slow crystal stopped");
  property p_bit4; psel && penable && !pwrite && paddr == 32'h0 |-> !prdata[4] && prdata[31:8] == 24'h0;
  endproperty
  a_bit4: assert property (p_bit4) else $error("select bit four set");
  property p_core_off; mode[5:2] != 4'h0 && $past(mode[5:2]) != 4'h0 |-> !core_run; endproperty
  a_core_off: assert property (p_core_off) else $error("core runs when halted");
  property p_slow_periph; mode == 6'h04 && $past(mode) == 6'h04 |-> !slow_periph_clock; endproperty
  a_slow_periph: assert property (p_slow_periph) else $error("slow clock in sleep");
  c_sleep: cover property (mode == 6'h04);
  c_idle1: cover property (mode == 6'h10);
  c_slow: cover property (mode == 6'h02);
endmodule // scm_clock_mode_props
`default_nettype wire

// [scm_osc_model.sv]
// Oscillator model giving waveforms and settle levels
`timescale 1ns/1ns
`default_nettype none
module scm_osc_model #(
  parameter int SETTLE = 30
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] run,
  output logic [3:0] osc,
  output logic [2:0] rdy
);
  // Half period in system clocks per oscillator
  function automatic int half_of(input int i);
    half_of = (i == 0) ? 3 : (i == 1) ? 5 : (i == 2) ? 20 : 16;
  endfunction
  int cnt [4];
  int up [4];
  assign rdy = {up[3] >= SETTLE, up[1] >= SETTLE, up[0] >= SETTLE};
  // Stopped oscillators stay low and lose their settle time
  always_ff @(posedge clk_sys or posedge rst) begin
    for (int i = 0; i < 4; i++) begin
      if (rst || !run[i]) begin
        cnt[i] <= 0;
        up[i] <= 0;
        osc[i] <= 1'b0;
      end else begin
        cnt[i] <= (cnt[i] == half_of(i) - 1) ? 0 : cnt[i] + 1;
        if (cnt[i] == half_of(i) - 1) osc[i] <= ~osc[i];
        if (up[i] < SETTLE) up[i] <= up[i] + 1;
      end
    end
  end
endmodule // scm_osc_model
`default_nettype wire

// [test_system_clock_mode_control.sv]
// Testbench for system clock and mode control
`timescale 1ns/1ns
`default_nettype none
module test_system_clock_mode_control;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic halt_req = 1'b0, wake_req = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, system_clock, fast_periph_clock, slow_periph_clock, rtc_clock, core_run;
  logic fast_rc_run, fast_crystal_run, slow_rc_run, slow_crystal_run, range_out;
  logic [2:0] fast_rc_freq_applied, rdy;
  logic [5:0] mode;
  logic [3:0] osc, run;
  int n_mismatch = 0, checks_done = 0;
  always #2 clk_sys = ~clk_sys;
  assign run = {slow_crystal_run, slow_rc_run, fast_crystal_run, fast_rc_run};
  scm_clock_mode #(.DIV_W(6)) u_scm_clock_mode (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
    .wake_req(wake_req), .internal_fast_rc(osc[0]), .external_fast_crystal(osc[1]),
    .internal_slow_rc(osc[2]), .external_slow_crystal(osc[3]), .fast_rc_ready(rdy[0]),
    .fast_crystal_ready(rdy[1]), .slow_crystal_ready(rdy[2]), .system_clock(system_clock),
    .fast_periph_clock(fast_periph_clock), .slow_periph_clock(slow_periph_clock),
    .rtc_clock(rtc_clock), .core_run(core_run), .fast_rc_run(fast_rc_run),
    .fast_crystal_run(fast_crystal_run), .slow_rc_run(slow_rc_run),
    .slow_crystal_run(slow_crystal_run), .fast_rc_freq_applied(fast_rc_freq_applied),
    .fast_crystal_range_out(range_out), .mode(mode));
  scm_osc_model u_scm_osc_model (.clk_sys(clk_sys), .rst(rst), .run(run), .osc(osc), .rdy(rdy));
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task cmp_per(input int got, input int exp);
    checks_done++;
    if (got < exp - 1 || got > exp + 1) begin
      n_mismatch++;
      $display("mismatch at %0t: period %0d want %0d", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic err);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (k == 50) begin
      n_mismatch++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rdr(input logic [31:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task poll(input logic [31:0] a);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < 100 && r[1] !== 1'b1; k++) rdr(a, r);
    cmp({31'h0, r[1]}, 32'h1);
  endtask
  task meas(input int which, output int p);
    int e1;
    logic prv, cur;
    e1 = -1;
    p = 0;
    prv = 1'b1;
    for (int k = 0; k < 2000; k++) begin
      @(negedge clk_sys);
      cur = (which == 0) ? system_clock : (which == 1) ? rtc_clock : fast_periph_clock;
      if (cur === 1'b1 && prv === 1'b0) begin
        if (e1 >= 0) begin
          p = k - e1;
          break;
        end
        e1 = k;
      end
      prv = cur;
    end
  endtask
  task pulse(input logic h);
    @(posedge clk_sys);
    if (h) halt_req <= 1'b1;
    else wake_req <= 1'b1;
    @(posedge clk_sys);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task t_reset;
    logic [31:0] r;
    rdr(32'h0, r);
    cmp(r, 32'h0);
    rdr(32'h4, r);
    cmp(r & 32'hfffffffd, 32'h1);
    rdr(32'h8, r);
    cmp(r, 32'h0);
    rdr(32'hc, r);
    cmp(r, 32'h0);
  endtask
  task t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b1, 32'h10, 32'hff, r, e);
    cmp({31'h0, e}, 32'h1);
    apb(1'b0, 32'h20, 32'h0, r, e);
    cmp({31'h0, e}, 32'h1);
    cmp(r, 32'h0);
    wr(32'h0, 32'hff);
    rdr(32'h0, r);
    cmp(r, 32'hef);
    wr(32'h0, 32'h0);
    wr(32'h8, 32'h4);
    repeat (2) @(negedge clk_sys);
    cmp({31'h0, range_out}, 32'h1);
    wr(32'h8, 32'h0);
  endtask
  task t_rcfreq;
    logic [2:0] old;
    for (int c = 0; c < 8; c++) begin
      old = fast_rc_freq_applied;
      wr(32'h4, {27'h0, c[2:0], 2'h1});
      @(negedge clk_sys);
      cmp({29'h0, fast_rc_freq_applied}, {29'h0, old});
      for (int k = 0; k < 60 && fast_rc_freq_applied !== c[2:0]; k++) @(negedge clk_sys);
      cmp({29'h0, fast_rc_freq_applied}, {29'h0, c[2:0]});
    end
  endtask
  task t_ratios;
    int p;
    for (int c = 0; c < 7; c++) begin
      wr(32'h0, {24'h0, c[2:0], 5'h0});
      repeat (400) @(negedge clk_sys);
      meas(0, p);
      cmp_per(p, 6 << c);
    end
  endtask
  task t_sources;
    logic [31:0] r;
    int p;
    wr(32'h8, 32'h1);
    rdr(32'h8, r);
    cmp({31'h0, r[1]}, 32'h0);
    poll(32'h8);
    wr(32'h8, 32'h5);
    rdr(32'h8, r);
    cmp(r, 32'h3);
    cmp({31'h0, range_out}, 32'h0);
    wr(32'h0, 32'h08);
    repeat (200) @(negedge clk_sys);
    meas(0, p);
    cmp_per(p, 10);
    wr(32'hc, 32'h1);
    poll(32'hc);
    wr(32'h0, 32'hec);
    repeat (300) @(negedge clk_sys);
    meas(0, p);
    cmp_per(p, 32);
    cmp({26'h0, mode}, 32'h2);
    meas(1, p);
    cmp_per(p, 32);
    meas(2, p);
    cmp_per(p, 10);
    wr(32'h0, 32'he0);
    repeat (300) @(negedge clk_sys);
    meas(0, p);
    cmp_per(p, 40);
  endtask
  task t_halt;
    logic [5:0] want [4];
    int p;
    want = '{6'h04, 6'h08, 6'h20, 6'h10};
    for (int i = 0; i < 4; i++) begin
      wr(32'h0, 32'he0 | i);
      pulse(1'b1);
      cmp({26'h0, mode}, {26'h0, want[i]});
      cmp({31'h0, core_run}, 32'h0);
      if (i == 1 || i == 2) begin
        meas(0, p);
        cmp_per(p, (i == 1) ? 40 : 0);
      end
      if (i == 0) begin
        repeat (300) @(negedge clk_sys);
        meas(1, p);
        cmp_per(p, 256);
      end
      pulse(1'b0);
      cmp({26'h0, mode}, 32'h2);
    end
  endtask
  task t_freeze;
    logic [5:0] m;
    logic s;
    @(posedge clk_sys);
    ce <= 1'b0;
    @(negedge clk_sys);
    m = mode;
    s = system_clock;
    repeat (60) @(negedge clk_sys);
    cmp({25'h0, mode, system_clock}, {25'h0, m, s});
    @(posedge clk_sys);
    ce <= 1'b1;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_rcfreq();
    t_ratios();
    t_sources();
    t_halt();
    t_freeze();
    wrap_up();
  end
  initial begin
    #360000;
    n_mismatch++;
    wrap_up();
  end
endmodule // test_system_clock_mode_control
bind scm_clock_mode scm_clock_mode_props u_scm_clock_mode_props (.clk_sys(clk_sys), .rst(rst),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .halt_req(halt_req), .mode(mode), .core_run(core_run),
  .fast_rc_run(fast_rc_run), .fast_crystal_run(fast_crystal_run), .slow_rc_run(slow_rc_run),
  .slow_crystal_run(slow_crystal_run), .slow_periph_clock(slow_periph_clock));
`default_nettype wire
